// ==== hdl/temp_limit_offset_result_regs.sv ====
// Limit, offset, one-shot and remote result registers with read lock
// Behaviour
// - Local low limit held, compared per conversion
// - Remote high limit upper byte held, compared
// - Remote low limit upper byte held, compared
// - Any write to trigger while idle starts one shutdown conversion
// - Result fraction in bits 7..4, rest zero
// - Result bytes read-only, refreshed per conversion
// - Reading high byte first locks low byte
// - Reading low byte first locks high byte
// - Lock drops when another register is read
// - Offset added to every remote conversion
// - Offset upper byte read/write, one degree LSB
// - Shutdown finishes current conversion then stops
// - Offset fraction bits 7..4 complete 12 bits
`timescale 1ns/100ps
`default_nettype none
module temp_limit_offset_result_regs (
  input wire logic mclk, // 20 MHz clock
  input wire logic rst_b, // Async reset, active low
  input wire logic regWrite, // Host write strobe, one cycle
  input wire logic regRead, // Host read strobe, one cycle
  input wire logic [7:0] regAddr, // Register offset
  input wire logic [7:0] regWdata, // Write data
  output logic [7:0] regRdata, // Read data, valid cycle after strobe
  input wire logic shutdown_control, // Shutdown bit from configuration
  input wire logic [3:0] remote_offset_fraction_bits, // Offset low nibble
  input wire logic [3:0] remote_high_limit_fraction, // High limit nibble
  input wire logic [3:0] remote_low_limit_fraction, // Low limit nibble
  input wire logic [11:0] localTemp, // Local measurement
  input wire logic [11:0] adcRemote, // Raw remote converter value
  input wire logic convDone, // Converter finished, one cycle
  output logic convStart, // Start a conversion, one cycle
  output logic [7:0] remoteResultUpper, // Remote result high byte
  output logic localBelowLow, // Local below low limit
  output logic remoteAboveHigh, // Remote above high limit
  output logic remoteBelowLow, // Remote below low limit
  output logic converting // Conversion in progress
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] local_low_limit_bits;
  logic [7:0] remote_high_limit_upper_bits;
  logic [7:0] remote_low_limit_upper_bits;
  logic [7:0] remote_offset_upper_bits;
  logic [3:0] remote_result_fraction_bits;
  logic lockLow;
  logic lockHigh;
  logic next_lockLow;
  logic next_lockHigh;
  logic compareStrobe;
  temp_limit_pkg::seq_state_t seqState;
  temp_limit_pkg::seq_state_t next_seqState;

  // Write select decode
  wire wLocalLow = regWrite && regAddr == temp_limit_pkg::WR_LOCAL_LOW_LIMIT;
  wire wRemHigh = regWrite && regAddr == temp_limit_pkg::WR_REMOTE_HIGH_LIMIT;
  wire wRemLow = regWrite && regAddr == temp_limit_pkg::WR_REMOTE_LOW_LIMIT;
  wire wOffset = regWrite && regAddr == temp_limit_pkg::WR_OFFSET_UPPER;
  wire wTrigger = regWrite && regAddr == temp_limit_pkg::WR_SINGLE_TRIGGER;

  // Read select decode
  wire selLocalLow = regAddr == temp_limit_pkg::RD_LOCAL_LOW_LIMIT;
  wire selRemHigh = regAddr == temp_limit_pkg::RD_REMOTE_HIGH_LIMIT;
  wire selRemLow = regAddr == temp_limit_pkg::RD_REMOTE_LOW_LIMIT;
  wire selFrac = regAddr == temp_limit_pkg::RD_RESULT_FRACTION;
  wire selUpper = regAddr == temp_limit_pkg::RD_RESULT_UPPER;
  wire selOffset = regAddr == temp_limit_pkg::RD_OFFSET_UPPER;
  wire rdFrac = regRead && selFrac;
  wire rdUpper = regRead && selUpper;
  wire rdOther = regRead && !rdFrac && !rdUpper;

  ////////////////////////////////////////////////////////////////////////////
  // limit and offset registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      local_low_limit_bits <= temp_limit_pkg::RST_LOCAL_LOW_LIMIT;
      remote_high_limit_upper_bits <= temp_limit_pkg::RST_REMOTE_HIGH_LIMIT;
      remote_low_limit_upper_bits <= temp_limit_pkg::RST_REMOTE_LOW_LIMIT;
      remote_offset_upper_bits <= temp_limit_pkg::RST_OFFSET_UPPER;
    end else begin
      if (wLocalLow) local_low_limit_bits <= regWdata;
      if (wRemHigh) remote_high_limit_upper_bits <= regWdata;
      if (wRemLow) remote_low_limit_upper_bits <= regWdata;
      if (wOffset) remote_offset_upper_bits <= regWdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: continuous unless shut down
  wire trigger = wTrigger && shutdown_control &&
                 seqState == temp_limit_pkg::SEQ_IDLE;
  always_comb begin
    next_seqState = seqState;
    case (seqState)
      temp_limit_pkg::SEQ_IDLE: begin
        if (!shutdown_control || trigger) begin
          next_seqState = temp_limit_pkg::SEQ_BUSY;
        end
      end
      temp_limit_pkg::SEQ_BUSY: begin
        if (convDone) next_seqState = temp_limit_pkg::SEQ_DONE;
      end
      temp_limit_pkg::SEQ_DONE: begin
        // One idle cycle between conversions
        next_seqState = temp_limit_pkg::SEQ_IDLE;
      end
      default: next_seqState = temp_limit_pkg::SEQ_IDLE;
    endcase
  end
  wire startNow = seqState == temp_limit_pkg::SEQ_IDLE &&
                  next_seqState == temp_limit_pkg::SEQ_BUSY;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      seqState <= temp_limit_pkg::SEQ_IDLE;
      convStart <= 1'b0;
      converting <= 1'b0;
    end else begin
      seqState <= next_seqState;
      convStart <= startNow;
      converting <= next_seqState == temp_limit_pkg::SEQ_BUSY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // offset sum; offset fraction; 12-bit offset
  wire [11:0] offsetFull = {remote_offset_upper_bits,
                            remote_offset_fraction_bits};
  wire [11:0] remoteSum = adcRemote + offsetFull;
  wire doneNow = convDone && seqState == temp_limit_pkg::SEQ_BUSY;
  wire [7:0] sumUpper =
    remoteSum[temp_limit_pkg::TEMP_W-1:temp_limit_pkg::FRAC_W];
  wire [3:0] sumFrac = remoteSum[temp_limit_pkg::FRAC_W-1:0];

  // high read first locks low; low read first locks high; other read
  always_comb begin
    next_lockLow = lockLow;
    next_lockHigh = lockHigh;
    if (rdUpper) begin
      next_lockLow = !lockHigh;
      next_lockHigh = 1'b0;
    end else if (rdFrac) begin
      next_lockLow = 1'b0;
      next_lockHigh = !lockLow;
    end else if (rdOther) begin
      next_lockLow = 1'b0;
      next_lockHigh = 1'b0;
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lockLow <= 1'b0;
      lockHigh <= 1'b0;
    end else begin
      lockLow <= next_lockLow;
      lockHigh <= next_lockHigh;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      remoteResultUpper <= temp_limit_pkg::RST_RESULT;
      remote_result_fraction_bits <= temp_limit_pkg::RSVD_ZERO;
      compareStrobe <= 1'b0;
    end else begin
      compareStrobe <= doneNow;
      // a lock taken at this read edge already holds
      if (doneNow && !next_lockHigh) remoteResultUpper <= sumUpper;
      if (doneNow && !next_lockLow) remote_result_fraction_bits <= sumFrac;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire [7:0] rdMux =
    selLocalLow ? local_low_limit_bits :
    selRemHigh ? remote_high_limit_upper_bits :
    selRemLow ? remote_low_limit_upper_bits :
    selFrac ? {remote_result_fraction_bits, temp_limit_pkg::RSVD_ZERO} :
    selUpper ? remoteResultUpper :
    selOffset ? remote_offset_upper_bits :
    temp_limit_pkg::READ_NONE;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata <= temp_limit_pkg::READ_NONE;
    end else if (regRead) begin
      regRdata <= rdMux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // limits as 12-bit
  wire [11:0] remHighFull = {remote_high_limit_upper_bits,
                             remote_high_limit_fraction};
  wire [11:0] remLowFull = {remote_low_limit_upper_bits,
                            remote_low_limit_fraction};
  wire [11:0] locLowFull = {local_low_limit_bits, temp_limit_pkg::RSVD_ZERO};
  wire [11:0] remStored = {remoteResultUpper, remote_result_fraction_bits};

  limit_compare #(.W(temp_limit_pkg::TEMP_W)) remoteCmp (
    .mclk(mclk),
    .rst_b(rst_b),
    .sample(compareStrobe),
    .temp(remStored),
    .highLimit(remHighFull),
    .lowLimit(remLowFull),
    .aboveHigh(remoteAboveHigh),
    .belowLow(remoteBelowLow)
  );
  limit_compare #(.W(temp_limit_pkg::TEMP_W)) localCmp (
    .mclk(mclk),
    .rst_b(rst_b),
    .sample(compareStrobe),
    .temp(localTemp),
    .highLimit(locLowFull),
    .lowLimit(locLowFull),
    .aboveHigh(),
    .belowLow(localBelowLow)
  );
endmodule
`default_nettype wire

// ==== hdl/temp_limit_pkg.sv ====
// Register map and field constants of the limit, offset and result bank
package temp_limit_pkg;
  // Read and write offsets as printed
  localparam logic [7:0] RD_LOCAL_LOW_LIMIT = 8'h06;
  localparam logic [7:0] WR_LOCAL_LOW_LIMIT = 8'h0C;
  localparam logic [7:0] RD_REMOTE_HIGH_LIMIT = 8'h07;
  localparam logic [7:0] WR_REMOTE_HIGH_LIMIT = 8'h0D;
  localparam logic [7:0] RD_REMOTE_LOW_LIMIT = 8'h08;
  localparam logic [7:0] WR_REMOTE_LOW_LIMIT = 8'h0E;
  localparam logic [7:0] WR_SINGLE_TRIGGER = 8'h0F;
  localparam logic [7:0] RD_RESULT_FRACTION = 8'h10;
  localparam logic [7:0] RD_OFFSET_UPPER = 8'h11;
  localparam logic [7:0] WR_OFFSET_UPPER = 8'h11;
  // Result high byte read offset (outside this bank, needed for the lock)
  localparam logic [7:0] RD_RESULT_UPPER = 8'h01;
  // Reset values
  localparam logic [7:0] RST_LOCAL_LOW_LIMIT = 8'h00;
  localparam logic [7:0] RST_REMOTE_HIGH_LIMIT = 8'h55;
  localparam logic [7:0] RST_REMOTE_LOW_LIMIT = 8'h00;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic [7:0] RST_OFFSET_UPPER = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;
  // Fraction field: bits 7..4, lower nibble reserved as zero
  localparam int FRAC_W = 4;
  localparam int TEMP_W = 12;
  localparam logic [3:0] RSVD_ZERO = 4'h0;
  // Conversion sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_BUSY = 2'b01,
    SEQ_DONE = 2'b10
  } seq_state_t;
endpackage

// ==== hdl/limit_compare.sv ====
// Signed 12-bit window compare of one temperature against two limits
`timescale 1ns/100ps
`default_nettype none
module limit_compare #(
  parameter int W = 12
) (
  input wire logic mclk, // Clock
  input wire logic rst_b, // Async reset, active low
  input wire logic sample, // Compare strobe
  input wire logic [W-1:0] temp, // Temperature
  input wire logic [W-1:0] highLimit, // High limit
  input wire logic [W-1:0] lowLimit, // Low limit
  output logic aboveHigh, // Temp above high limit
  output logic belowLow // Temp below low limit
);
  wire gtHigh = $signed(temp) > $signed(highLimit);
  wire ltLow = $signed(temp) < $signed(lowLimit);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      aboveHigh <= 1'b0;
      belowLow <= 1'b0;
    end else if (sample) begin
      aboveHigh <= gtHigh;
      belowLow <= ltLow;
    end
  end
endmodule
`default_nettype wire

// ==== test/temp_regs_props.sv ====
// Port checker for the limit, offset and result bank
`timescale 1ns/100ps
`default_nettype none
module temp_regs_props (
  input wire logic mclk, // Clock
  input wire logic rst_b, // Reset
  input wire logic regWrite, // Write strobe
  input wire logic regRead, // Read strobe
  input wire logic [7:0] regAddr, // Offset
  input wire logic [7:0] regWdata, // Write data
  input wire logic [7:0] regRdata, // Read data
  input wire logic shutdown_control, // Shutdown
  input wire logic convDone, // Done
  input wire logic convStart, // Start
  input wire logic [7:0] remoteResultUpper, // Result
  input wire logic localBelowLow, // Flag
  input wire logic remoteAboveHigh, // Flag
  input wire logic remoteBelowLow, // Flag
  input wire logic converting // Busy
);
  logic [7:0] lastRd;
  wire logic trig = regWrite && regAddr == 8'h0F && shutdown_control;
  wire logic [2:0] flags = {localBelowLow, remoteAboveHigh, remoteBelowLow};
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b) lastRd <= 8'h00;
    else if (regRead) lastRd <= regAddr;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence lowFirst;
    regRead && regAddr == 8'h10 && lastRd != 8'h01 ##1 !regRead [*2];
  endsequence
  chk_start_pulse: assert property (convStart |=> !convStart)
    else $error("start pulse too long");
  chk_trig_start: assert property (trig && !converting && !convStart
    && !$past(converting) |=> convStart)
    else $error("trigger did not start");
  chk_shut_quiet: assert property (convStart && $past(shutdown_control)
    |-> $past(regWrite) && $past(regAddr) == 8'h0F)
    else $error("start while shut down");
  chk_rsvd_zero: assert property (regRead && regAddr == 8'h10 |=>
    regRdata[3:0] == 4'h0) else $error("reserved bits set");
  chk_result_hold: assert property (!$stable(remoteResultUpper) |->
    $past(convDone)) else $error("result moved without conversion");
  chk_flag_hold: assert property (!$stable(flags) |->
    $past(convDone, 2)) else $error("flag moved without compare");
  chk_offset_back: assert property (regWrite && regAddr == 8'h11 ##2
    regRead && regAddr == 8'h11 |=> regRdata == $past(regWdata, 3))
    else $error("offset readback wrong");
  chk_upper_lock: assert property (lowFirst |->
    $stable(remoteResultUpper)) else $error("locked byte changed");
endmodule
bind temp_limit_offset_result_regs temp_regs_props temp_regs_props_inst (
  .mclk, .rst_b, .regWrite, .regRead, .regAddr, .regWdata, .regRdata,
  .shutdown_control, .convDone, .convStart, .remoteResultUpper,
  .localBelowLow, .remoteAboveHigh, .remoteBelowLow, .converting);
`default_nettype wire

// ==== test/adc_model.sv ====
// Behavioural remote converter answering start pulses
`timescale 1ns/100ps
`default_nettype none
module adc_model (
  input wire logic mclk, // Clock
  input wire logic convStart, // Start pulse
  input wire logic [11:0] sampleValue, // Value to deliver
  output logic convDone = 1'b0, // Done pulse
  output logic [11:0] adcRemote = 12'h000 // Raw value, valid with done
);
  int cnt = 0;
  // Value only valid in the done cycle, garbage otherwise
  always @(posedge mclk) begin
    #1;
    cnt = convStart ? 4 : (cnt > 0 ? cnt - 1 : 0);
    convDone = (cnt == 1);
    adcRemote = (cnt == 1) ? sampleValue : ~sampleValue;
  end
endmodule
`default_nettype wire

// ==== test/temp_limit_offset_result_regs_tb.sv ====
// Self-checking bench for the limit, offset and result bank
`timescale 1ns/100ps
`default_nettype none
module temp_limit_offset_result_regs_tb;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic shutdown_control = 1'b1;
  logic [3:0] remote_offset_fraction_bits = 4'h8;
  logic [3:0] remote_high_limit_fraction = 4'h0;
  logic [3:0] remote_low_limit_fraction = 4'h0;
  logic [11:0] localTemp = 12'h100;
  logic [11:0] sampleValue = 12'h000;
  logic [11:0] adcRemote;
  logic [7:0] regRdata, remoteResultUpper, rv;
  logic convDone, convStart, converting;
  logic localBelowLow, remoteAboveHigh, remoteBelowLow;
  int fails = 0;
  int check_count = 0;
  localparam logic [7:0] RA [5] = '{8'h06, 8'h07, 8'h08, 8'h10, 8'h11};
  localparam logic [7:0] RZ [5] = '{8'h00, 8'h55, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] WA [5] = '{8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h11};
  localparam logic [7:0] WD [5] = '{8'h20, 8'h60, 8'h40, 8'hFF, 8'h02};
  localparam logic [7:0] WE [5] = '{8'h20, 8'h60, 8'h40, 8'h00, 8'h02};
  temp_limit_offset_result_regs temp_limit_offset_result_regs_inst (
    .mclk, .rst_b, .regWrite, .regRead, .regAddr, .regWdata, .regRdata,
    .shutdown_control, .remote_offset_fraction_bits,
    .remote_high_limit_fraction, .remote_low_limit_fraction, .localTemp,
    .adcRemote, .convDone, .convStart, .remoteResultUpper, .localBelowLow,
    .remoteAboveHigh, .remoteBelowLow, .converting);
  adc_model adc_model_inst (.mclk, .convStart, .sampleValue, .convDone,
    .adcRemote);
  initial forever #25 mclk = ~mclk;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("fails %0d checks %0d", fails, check_count);
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) #1;
    {regWrite, regAddr, regWdata} = {1'b1, a, d};
    @(posedge mclk) #1;
    regWrite = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk) #1;
    {regRead, regAddr} = {1'b1, a};
    @(posedge mclk) #1;
    regRead = 1'b0;
    rv = regRdata;
  endtask
  task automatic wait_done();
    logic seen;
    seen = 1'b0;
    // Done pulse is looked at on the edge, where it stands settled
    for (int n = 0; n < 50 && !seen; n++) begin
      @(posedge mclk);
      seen = (convDone === 1'b1);
    end
    #1;
    if (!seen) begin
      fails++;
      final_report();
    end
    repeat (3) @(posedge mclk) #1;
  endtask
  task automatic conv(input logic [11:0] v);
    sampleValue = v;
    wr(8'h0F, 8'hA5);
    wait_done();
  endtask
  task automatic regs_scn();
    for (int i = 0; i < 5; i++) begin
      rd(RA[i]);
      check(rv, RZ[i]);
    end
    for (int i = 0; i < 5; i++) wr(WA[i], WD[i]);
    for (int i = 4; i >= 0; i--) begin
      rd(RA[i]);
      check(rv, WE[i]);
    end
    rd(8'h0F);
    check(rv, 8'h00);
  endtask
  task automatic conv_scn();
    conv(12'h3A5);
    check(remoteResultUpper, 8'h3C);
    rd(8'h10);
    check(rv, 8'hD0);
    check({5'h0, localBelowLow, remoteAboveHigh, remoteBelowLow}, 8'h05);
  endtask
  task automatic lock_scn();
    // high byte first, after a read that drops any old lock
    rd(8'h06);
    rd(8'h01);
    conv(12'h123);
    check(remoteResultUpper, 8'h14);
    rd(8'h10);
    check(rv, 8'hD0);
    rd(8'h06);
    conv(12'h123);
    rd(8'h10);
    check(rv, 8'hB0);
    conv(12'h200);
    check(remoteResultUpper, 8'h14);
    rd(8'h06);
    conv(12'h700);
    check(remoteResultUpper, 8'h72);
    check({7'h0, remoteAboveHigh}, 8'h01);
  endtask
  task automatic shut_scn();
    int starts;
    starts = 0;
    sampleValue = 12'h0F0;
    // Continuous mode for one start, then shutdown mid-conversion
    shutdown_control = 1'b0;
    @(posedge mclk) #1;
    shutdown_control = 1'b1;
    check({7'h0, converting}, 8'h01);
    wait_done();
    check(remoteResultUpper, 8'h11);
    check({5'h0, localBelowLow, remoteAboveHigh, remoteBelowLow}, 8'h05);
    for (int n = 0; n < 20; n++) begin
      @(posedge mclk) #1;
      if (convStart !== 1'b0) starts++;
    end
    check(8'(starts), 8'h00);
    check({7'h0, converting}, 8'h00);
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    #1 rst_b = 1'b1;
    regs_scn();
    conv_scn();
    lock_scn();
    shut_scn();
    final_report();
  end
endmodule
`default_nettype wire
